/* File: display_raster_timing_ctrl.v */
/*
  display_controller_core raster timing generator: programmable
  horizontal and vertical timing, sync and blank outputs with
  selectable polarity, border insert, blank-start flags, enable
  that stops at frame end, self-clearing soft reset.
  assumes: clk_in is the pixel clock; the pixel source answers
  pix_req_out with pix_data_in in the same cycle.
*/
`include "display_raster_timing_ctrl_consts.vh"

module display_raster_timing_ctrl (
  input wire clk_in,
  input wire arst_n_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output wire [31:0] reg_rdata_out,
  input wire [23:0] pix_data_in,
  output wire pix_req_out,
  output wire [23:0] rgb_out,
  output wire hsync_out,
  output wire vsync_out,
  output wire csync_out,
  output wire blank_out,
  output wire [1:0] endpoint_irq_status_out,
  output wire controller_running_flag_out
);

  localparam TW = `DRT_TW;
  // counter step at field width, so sums keep the width of the counters
  localparam [TW-1:0] ONE = {{(TW-1){1'b0}}, 1'b1};

  // counter sits inside (start, end]; fields are value minus one
  function in_win;
    input [TW-1:0] cnt;
    input [TW-1:0] lo;
    input [TW-1:0] hi;
    begin
      in_win = (cnt > lo) && (cnt <= hi);
    end
  endfunction

  // software configuration
  reg srst_ff; // one-cycle soft reset
  reg en_ff;
  reg [3:0] pol_ff; // hs, vs, cs, blank: 1 = active low
  reg [TW-1:0] h_tot_ff; // last pixel of a line
  reg [TW-1:0] h_act_ff; // last active pixel
  reg [TW-1:0] h_bs_ff; // blank begins after this pixel
  reg [TW-1:0] h_be_ff; // blank ends with this pixel
  reg [TW-1:0] h_ss_ff; // sync begins after this pixel
  reg [TW-1:0] h_se_ff; // sync ends with this pixel
  reg [TW-1:0] v_tot_ff; // last line of a frame
  reg [TW-1:0] v_act_ff; // last active line
  reg [TW-1:0] v_bs_ff; // vertical blank begins after this line
  reg [TW-1:0] v_be_ff; // vertical blank ends with this line
  reg [TW-1:0] v_ss_ff; // vertical sync begins after this line
  reg [TW-1:0] v_se_ff; // vertical sync ends with this line
  reg [23:0] border_ff;
  reg hbi_ff; // horizontal blank start flag
  reg vbi_ff; // vertical blank start flag
  reg [31:0] rdata_ff;

  // raster core
  reg run_ff;
  reg [TW-1:0] h_cnt_ff; // pixel within the line
  reg [TW-1:0] v_cnt_ff; // line within the frame
  reg vact_ln_ff; // line holds active pixels
  reg vbl_ln_ff; // line is vertically blanked
  reg vs_ln_ff; // line carries vertical sync

  // stage 1: regions of the current count
  reg s1_req_ff; // pixel fetched for this count
  reg s1_hb_ff; // horizontal blank, for the edge detect
  reg s1_bl_ff; // composite blank
  reg s1_bd_ff; // border pixel
  reg s1_hs_ff; // horizontal sync
  reg s1_vs_ff; // vertical sync

  // stage 2: pins
  reg [23:0] rgb_ff;
  reg hs_ff; // horizontal sync pin
  reg vs_ff; // vertical sync pin
  reg cs_ff; // composite sync pin
  reg bl_ff; // blank pin

  // write decode
  wire wr_ctrl = reg_wr_in && (reg_addr_in == `DRT_OFS_CTRL);
  wire wr_sts = reg_wr_in && (reg_addr_in == `DRT_OFS_STATUS);

  // line and frame ends
  wire h_last = (h_cnt_ff == h_tot_ff);
  wire v_last = (v_cnt_ff == v_tot_ff);
  // line that follows the current one, wrapping at frame end
  wire [TW-1:0] v_next = v_last ? {TW{1'b0}} : v_cnt_ff + ONE;

  // horizontal regions
  wire h_act = (h_cnt_ff <= h_act_ff);
  wire h_bl = in_win(h_cnt_ff, h_bs_ff, h_be_ff);
  wire h_sy = in_win(h_cnt_ff, h_ss_ff, h_se_ff);
  // one count ahead of the sync window: the vertical latches then reach
  // stage 1 at the same edge as the first sync count, so the pins move together
  wire hs_lead = (h_cnt_ff == h_ss_ff);

  // vertical regions for the following line
  wire nv_act = (v_next <= v_act_ff);
  wire nv_bl = in_win(v_next, v_bs_ff, v_be_ff);
  wire nv_sy = in_win(v_next, v_ss_ff, v_se_ff);

  // pixel and blank classification
  wire px_act = run_ff && h_act && vact_ln_ff;
  wire px_bl = !run_ff || h_bl || vbl_ln_ff;
  wire hb_rise = run_ff && h_bl && !s1_hb_ff;

  // control register, soft reset pulse, enable, polarities
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      srst_ff <= 1'b0;
      en_ff <= 1'b0;
      pol_ff <= `DRT_RST_POL;
    end else if (srst_ff) begin
      // self-clears after the one reset cycle
      srst_ff <= 1'b0;
      en_ff <= 1'b0;
      pol_ff <= `DRT_RST_POL;
    end else if (wr_ctrl) begin
      srst_ff <= reg_wdata_in[`DRT_CTRL_SRST];
      en_ff <= reg_wdata_in[`DRT_CTRL_EN];
      pol_ff <= reg_wdata_in[`DRT_CTRL_POL_BL:`DRT_CTRL_POL_HS];
    end
  end

  // timing and border registers; meant to change only while stopped
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      h_tot_ff <= `DRT_RST_H_TOTAL;
      h_act_ff <= `DRT_RST_H_ACTIVE;
      h_bs_ff <= `DRT_RST_H_BSTART;
      h_be_ff <= `DRT_RST_H_BEND;
      h_ss_ff <= `DRT_RST_H_SSTART;
      h_se_ff <= `DRT_RST_H_SEND;
      v_tot_ff <= `DRT_RST_V_TOTAL;
      v_act_ff <= `DRT_RST_V_ACTIVE;
      v_bs_ff <= `DRT_RST_V_BSTART;
      v_be_ff <= `DRT_RST_V_BEND;
      v_ss_ff <= `DRT_RST_V_SSTART;
      v_se_ff <= `DRT_RST_V_SEND;
      border_ff <= `DRT_RST_BORDER;
    end else if (srst_ff) begin
      // soft reset loads the same defaults as power-up
      h_tot_ff <= `DRT_RST_H_TOTAL;
      h_act_ff <= `DRT_RST_H_ACTIVE;
      h_bs_ff <= `DRT_RST_H_BSTART;
      h_be_ff <= `DRT_RST_H_BEND;
      h_ss_ff <= `DRT_RST_H_SSTART;
      h_se_ff <= `DRT_RST_H_SEND;
      v_tot_ff <= `DRT_RST_V_TOTAL;
      v_act_ff <= `DRT_RST_V_ACTIVE;
      v_bs_ff <= `DRT_RST_V_BSTART;
      v_be_ff <= `DRT_RST_V_BEND;
      v_ss_ff <= `DRT_RST_V_SSTART;
      v_se_ff <= `DRT_RST_V_SEND;
      border_ff <= `DRT_RST_BORDER;
    end else if (reg_wr_in) begin
      // no shadowing: a write while running takes effect at once
      case (reg_addr_in)
        `DRT_OFS_H_SIZE: begin
          h_tot_ff <= reg_wdata_in[`DRT_HI+TW-1:`DRT_HI];
          h_act_ff <= reg_wdata_in[`DRT_LO+TW-1:`DRT_LO];
        end
        `DRT_OFS_H_BLANK: begin
          h_be_ff <= reg_wdata_in[`DRT_HI+TW-1:`DRT_HI];
          h_bs_ff <= reg_wdata_in[`DRT_LO+TW-1:`DRT_LO];
        end
        `DRT_OFS_H_SYNC: begin
          h_se_ff <= reg_wdata_in[`DRT_HI+TW-1:`DRT_HI];
          h_ss_ff <= reg_wdata_in[`DRT_LO+TW-1:`DRT_LO];
        end
        `DRT_OFS_V_SIZE: begin
          v_tot_ff <= reg_wdata_in[`DRT_HI+TW-1:`DRT_HI];
          v_act_ff <= reg_wdata_in[`DRT_LO+TW-1:`DRT_LO];
        end
        `DRT_OFS_V_BLANK: begin
          v_be_ff <= reg_wdata_in[`DRT_HI+TW-1:`DRT_HI];
          v_bs_ff <= reg_wdata_in[`DRT_LO+TW-1:`DRT_LO];
        end
        `DRT_OFS_V_SYNC: begin
          v_se_ff <= reg_wdata_in[`DRT_HI+TW-1:`DRT_HI];
          v_ss_ff <= reg_wdata_in[`DRT_LO+TW-1:`DRT_LO];
        end
        `DRT_OFS_BORDER: begin
          border_ff <= reg_wdata_in[23:0];
        end
        default: begin
          // other offsets hold no timing field
        end
      endcase
    end
  end

  // blank-start flags: set wins over a write-one clear
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hbi_ff <= 1'b0;
      vbi_ff <= 1'b0;
    end else if (srst_ff) begin
      hbi_ff <= 1'b0;
      vbi_ff <= 1'b0;
    end else begin
      hbi_ff <= hb_rise | (hbi_ff & ~(wr_sts & reg_wdata_in[`DRT_STS_HBI]));
      vbi_ff <= (run_ff & hs_lead & nv_bl & ~vbl_ln_ff) |
                (vbi_ff & ~(wr_sts & reg_wdata_in[`DRT_STS_VBI]));
    end
  end

  // read data, valid the cycle after the strobe
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_ff <= 32'h00000000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `DRT_OFS_CTRL: rdata_ff <= {26'h0000000, pol_ff, en_ff, srst_ff};
        `DRT_OFS_STATUS: rdata_ff <= {29'h00000000, vbi_ff, hbi_ff, run_ff};
        `DRT_OFS_H_SIZE: rdata_ff <= {4'h0, h_tot_ff, 4'h0, h_act_ff};
        `DRT_OFS_H_BLANK: rdata_ff <= {4'h0, h_be_ff, 4'h0, h_bs_ff};
        `DRT_OFS_H_SYNC: rdata_ff <= {4'h0, h_se_ff, 4'h0, h_ss_ff};
        `DRT_OFS_V_SIZE: rdata_ff <= {4'h0, v_tot_ff, 4'h0, v_act_ff};
        `DRT_OFS_V_BLANK: rdata_ff <= {4'h0, v_be_ff, 4'h0, v_bs_ff};
        `DRT_OFS_V_SYNC: rdata_ff <= {4'h0, v_se_ff, 4'h0, v_ss_ff};
        `DRT_OFS_BORDER: rdata_ff <= {8'h00, border_ff};
        default: rdata_ff <= 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // raster counters and run state
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_ff <= 1'b0;
      h_cnt_ff <= {TW{1'b0}};
      v_cnt_ff <= {TW{1'b0}};
      vact_ln_ff <= 1'b0;
      vbl_ln_ff <= 1'b0;
      vs_ln_ff <= 1'b0;
    end else if (srst_ff) begin
      run_ff <= 1'b0;
      h_cnt_ff <= {TW{1'b0}};
      v_cnt_ff <= {TW{1'b0}};
      vact_ln_ff <= 1'b0;
      vbl_ln_ff <= 1'b0;
      vs_ln_ff <= 1'b0;
    end else if (!run_ff) begin
      // stopped: counters held at pixel 0 of line 0
      h_cnt_ff <= {TW{1'b0}};
      v_cnt_ff <= {TW{1'b0}};
      if (en_ff) begin
        run_ff <= 1'b1;
        // line 0 state, since no hsync edge has latched it yet
        vact_ln_ff <= 1'b1;
        vbl_ln_ff <= in_win({TW{1'b0}}, v_bs_ff, v_be_ff);
        vs_ln_ff <= in_win({TW{1'b0}}, v_ss_ff, v_se_ff);
      end
    end else begin
      h_cnt_ff <= h_last ? {TW{1'b0}} : h_cnt_ff + ONE;
      if (h_last) begin
        v_cnt_ff <= v_next;
      end
      // vertical outputs move with the hsync leading edge
      if (hs_lead) begin
        vact_ln_ff <= nv_act;
        vbl_ln_ff <= nv_bl;
        vs_ln_ff <= nv_sy;
      end
      // disable is honoured only at the end of the frame
      if (h_last && v_last && !en_ff) begin
        run_ff <= 1'b0;
        vact_ln_ff <= 1'b0;
        vbl_ln_ff <= 1'b0;
        vs_ln_ff <= 1'b0;
      end
    end
  end

  // stage 1: classify the current count
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_req_ff <= 1'b0;
      s1_hb_ff <= 1'b1;
      s1_bl_ff <= 1'b1;
      s1_bd_ff <= 1'b0;
      s1_hs_ff <= 1'b0;
      s1_vs_ff <= 1'b0;
    end else begin
      s1_req_ff <= px_act;
      // forced high while stopped so a restart gives no false edge
      s1_hb_ff <= !run_ff || h_bl;
      s1_bl_ff <= px_bl;
      s1_bd_ff <= run_ff && !px_act && !px_bl;
      s1_hs_ff <= run_ff && h_sy;
      s1_vs_ff <= run_ff && vs_ln_ff;
    end
  end

  // stage 2: colour mux and polarity at the pins
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rgb_ff <= 24'h000000;
      hs_ff <= 1'b0;
      vs_ff <= 1'b0;
      cs_ff <= 1'b0;
      bl_ff <= 1'b0;
    end else begin
      // the pixel source answers the request in the same cycle
      if (s1_req_ff) begin
        rgb_ff <= pix_data_in;
      end else if (s1_bd_ff) begin
        rgb_ff <= border_ff;
      end else begin
        rgb_ff <= 24'h000000;
      end
      hs_ff <= s1_hs_ff ^ pol_ff[0];
      vs_ff <= s1_vs_ff ^ pol_ff[1];
      cs_ff <= (s1_hs_ff | s1_vs_ff) ^ pol_ff[2];
      bl_ff <= s1_bl_ff ^ pol_ff[3];
    end
  end

  // pins straight from flops
  assign reg_rdata_out = rdata_ff;
  assign pix_req_out = s1_req_ff;
  assign rgb_out = rgb_ff;
  assign hsync_out = hs_ff;
  assign vsync_out = vs_ff;
  assign csync_out = cs_ff;
  assign blank_out = bl_ff;
  assign endpoint_irq_status_out = {vbi_ff, hbi_ff};
  assign controller_running_flag_out = run_ff;

endmodule

/* File: display_raster_timing_ctrl_consts.vh */
/*
  constants of the raster timing and control core: register offsets,
  field positions, reset values.
  assumes: included by bare name into the core module only.
*/
// Summary of operation
// - soft reset bit restores defaults, self-clears
// - enabled: fetch pixels, drive colour and timing
// - disable finishes current frame, then stops
// - status bit shows stopped; software polls it
// - pixel counter per clock, line per line
// - all timing fields hold value minus one
// - line total spans active, borders, porches, sync
// - first pixel is 0; active below total
// - horizontal blank starts at programmed position
// - horizontal blank ends at programmed position
// - hsync spans programmed start to end
// - frame total spans lines, borders, porches, sync
// - active height minus one; first line 0
// - vertical blank starts at programmed line
// - vertical blank ends at programmed line
// - vsync spans programmed start to end line
// - vsync, vblank change at hsync leading edge
// - blank-start flags set, forwarded to endpoint
// - flags clear on write one or soft reset only
// - hsync, vsync, csync, blank outputs provided
// - each sync and blank polarity selectable
// - border regions show border colour
`ifndef DISPLAY_RASTER_TIMING_CTRL_CONSTS_VH
`define DISPLAY_RASTER_TIMING_CTRL_CONSTS_VH

// timing field width
`define DRT_TW 12

// register offsets
`define DRT_OFS_CTRL 8'h00
`define DRT_OFS_STATUS 8'h04
`define DRT_OFS_H_SIZE 8'h08
`define DRT_OFS_H_BLANK 8'h0c
`define DRT_OFS_H_SYNC 8'h10
`define DRT_OFS_V_SIZE 8'h14
`define DRT_OFS_V_BLANK 8'h18
`define DRT_OFS_V_SYNC 8'h1c
`define DRT_OFS_BORDER 8'h20

// control bits
`define DRT_CTRL_SRST 0
`define DRT_CTRL_EN 1
`define DRT_CTRL_POL_HS 2
`define DRT_CTRL_POL_VS 3
`define DRT_CTRL_POL_CS 4
`define DRT_CTRL_POL_BL 5

// status bits
`define DRT_STS_RUN 0
`define DRT_STS_HBI 1
`define DRT_STS_VBI 2

// pair fields: low field at bit 0, high field at bit 16
`define DRT_LO 0
`define DRT_HI 16

// reset values (640x480 timing, each minus one)
`define DRT_RST_H_TOTAL 12'h31f
`define DRT_RST_H_ACTIVE 12'h27f
`define DRT_RST_H_BSTART 12'h27f
`define DRT_RST_H_BEND 12'h31f
`define DRT_RST_H_SSTART 12'h28f
`define DRT_RST_H_SEND 12'h2ef
`define DRT_RST_V_TOTAL 12'h20c
`define DRT_RST_V_ACTIVE 12'h1df
`define DRT_RST_V_BSTART 12'h1df
`define DRT_RST_V_BEND 12'h20c
`define DRT_RST_V_SSTART 12'h1e9
`define DRT_RST_V_SEND 12'h1eb
`define DRT_RST_BORDER 24'h000000
`define DRT_RST_POL 4'h0

`endif

/* File: display_raster_timing_ctrl_chk.sv */
/* port checker for the raster timing core.
   assumes: bound to the core; polarity bits change only while stopped. */
module display_raster_timing_ctrl_chk (
  input wire clk_in,
  input wire arst_n_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_rdata_out,
  input wire [23:0] pix_data_in,
  input wire pix_req_out,
  input wire [23:0] rgb_out,
  input wire hsync_out,
  input wire vsync_out,
  input wire csync_out,
  input wire blank_out,
  input wire [1:0] endpoint_irq_status_out,
  input wire controller_running_flag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pol_ff; // shadow polarity {bl,cs,vs,hs}
  logic sr_ff; // soft reset write seen last cycle
  wire ctl_wr = reg_wr_in && reg_addr_in == 8'h00;
  wire run = controller_running_flag_out;
  wire bl_act = blank_out ^ pol_ff[3];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // soft reset drops the polarity too, so the shadow follows it
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pol_ff <= 4'h0;
      sr_ff <= 1'b0;
    end else begin
      sr_ff <= ctl_wr && reg_wdata_in[0];
      if (ctl_wr) pol_ff <= reg_wdata_in[0] ? 4'h0 : reg_wdata_in[5:2];
    end
  end
  a_enable_starts: assert property (ctl_wr && reg_wdata_in[1] && !reg_wdata_in[0] && !run |-> ##[1:2] run)
    else $error("raster did not start");
  a_stopped_quiet: assert property (!run && !$past(run) |-> !pix_req_out)
    else $error("pixel request while stopped");
  a_pix_to_rgb: assert property (pix_req_out |=> rgb_out == $past(pix_data_in))
    else $error("pixel colour not passed");
  a_req_unblanked: assert property (pix_req_out |=> !bl_act)
    else $error("active pixel blanked");
  a_blank_black: assert property (bl_act && $past(pol_ff, 2) == pol_ff |-> rgb_out == 24'h000000)
    else $error("colour during blank");
  a_csync_mix: assert property ($past(pol_ff, 2) == pol_ff |->
    csync_out == (((hsync_out ^ pol_ff[0]) | (vsync_out ^ pol_ff[1])) ^ pol_ff[2]))
    else $error("composite sync wrong");
  a_vs_on_hs: assert property (run && $past(run, 3) && $changed(vsync_out) |-> $changed(hsync_out))
    else $error("vsync moved off hsync edge");
  a_hflag_sticky: assert property (endpoint_irq_status_out[0] && !sr_ff && !(ctl_wr && reg_wdata_in[0])
    && !(reg_wr_in && reg_addr_in == 8'h04 && reg_wdata_in[1]) |=> endpoint_irq_status_out[0])
    else $error("blank flag lost");
  a_vflag_running: assert property ($rose(endpoint_irq_status_out[1]) |-> $past(run))
    else $error("vblank flag while stopped");
  a_hflag_in_blank: assert property ($rose(endpoint_irq_status_out[0]) |-> ##[0:2] bl_act)
    else $error("hblank flag outside blank");
endmodule

/* File: display_monitor_model.sv */
/* display monitor model: decodes sync and blank, measures line period,
   sync widths, frame height and lit pixels per line.
   assumes: pixel clock only; pol_in mirrors the control polarity bits. */
module display_monitor_model (
  input wire clk_in,
  input wire [3:0] pol_in,
  input wire hsync_in,
  input wire vsync_in,
  input wire blank_in,
  output logic [15:0] line_len_out,
  output logic [15:0] hs_len_out,
  output logic [15:0] frame_len_out,
  output logic [15:0] vs_len_out,
  output wire [15:0] lit_max_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire hs = hsync_in ^ pol_in[0]; // active-high views
  wire vs = vsync_in ^ pol_in[1];
  wire bl = blank_in ^ pol_in[3];
  logic hs_ff = 1'b0;
  logic vs_ff = 1'b0;
  logic [15:0] hcnt = 16'h0;
  logic [15:0] hw = 16'h0;
  logic [15:0] lcnt = 16'h0;
  logic [15:0] vw = 16'h0;
  logic [15:0] lit = 16'h0;
  logic [15:0] lit_max = 16'h0;
  wire hs_rise = hs && !hs_ff;
  wire vs_rise = vs && !vs_ff;
  assign lit_max_out = lit_max;
  // lit count kept only on steady lines, so idle time before lock is ignored
  always @(posedge clk_in) begin
    hs_ff <= hs;
    vs_ff <= vs;
    hcnt <= hs_rise ? 16'h1 : hcnt + 16'h1;
    hw <= hs_rise ? 16'h1 : hw + {15'h0, hs};
    lit <= hs_rise ? {15'h0, !bl} : lit + {15'h0, !bl};
    lcnt <= vs_rise ? 16'h1 : lcnt + {15'h0, hs_rise};
    vw <= vs_rise ? 16'h1 : vw + {15'h0, hs_rise && vs};
    if (hs_rise) line_len_out <= hcnt;
    if (hs_ff && !hs) hs_len_out <= hw;
    if (vs_rise) frame_len_out <= lcnt;
    if (vs_ff && !vs) vs_len_out <= vw;
    if (hs_rise && hcnt == line_len_out && lit > lit_max) lit_max <= lit;
  end
endmodule

/* File: tb_display_raster_timing_ctrl.sv */
/* testbench of the raster timing core with a monitor model.
   assumes: small timing 20 x 10, hsync and csync active low. */
module tb_display_raster_timing_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [23:0] pix_data_in = 24'h0;
  wire [31:0] reg_rdata_out;
  wire pix_req_out;
  wire [23:0] rgb_out;
  wire hsync_out;
  wire vsync_out;
  wire csync_out;
  wire blank_out;
  wire [1:0] endpoint_irq_status_out;
  wire controller_running_flag_out;
  wire [15:0] line_len, hs_len, frame_len, vs_len, lit_max;
  int fail_count = 0;
  int cmp_count = 0;
  display_raster_timing_ctrl uut (.clk_in, .arst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .pix_data_in, .pix_req_out, .rgb_out, .hsync_out, .vsync_out, .csync_out, .blank_out,
    .endpoint_irq_status_out, .controller_running_flag_out);
  display_monitor_model mon (.clk_in, .pol_in(4'h5), .hsync_in(hsync_out), .vsync_in(vsync_out),
    .blank_in(blank_out), .line_len_out(line_len), .hs_len_out(hs_len), .frame_len_out(frame_len),
    .vs_len_out(vs_len), .lit_max_out(lit_max));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  // pixel source: a new colour every clock
  always @(posedge clk_in) pix_data_in <= pix_data_in + 24'h1;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 check(reg_rdata_out, exp);
  endtask
  task automatic t_run();
    wr(8'h08, 32'h00130009);
    wr(8'h0c, 32'h0011000b);
    wr(8'h10, 32'h000f000d);
    wr(8'h14, 32'h00090004);
    wr(8'h18, 32'h00080005);
    wr(8'h1c, 32'h00070006);
    wr(8'h20, 32'h005a5a5a);
    wr(8'h00, 32'h00000014); // polarity set while stopped
    wr(8'h00, 32'h00000016);
    repeat (600) @(posedge clk_in);
    #1 check(32'(line_len), 32'h14);
    check(32'(hs_len), 32'h2);
    check(32'(frame_len), 32'ha);
    check(32'(vs_len), 32'h1);
    check(32'(lit_max), 32'he);
    // first right-border pixel reaches the pins one edge after the request drops
    @(negedge pix_req_out);
    @(posedge clk_in);
    #1 check(32'(rgb_out), 32'h5a5a5a);
    rd(8'h04, 32'h7);
  endtask
  task automatic t_stop();
    int n;
    n = 0;
    wr(8'h00, 32'h00000014);
    #1 check(32'(controller_running_flag_out), 32'h1);
    while (controller_running_flag_out !== 1'b0 && n < 300) begin
      @(posedge clk_in);
      #1 n++;
    end
    check(32'(n > 100 && n <= 200), 32'h1);
    repeat (3) @(posedge clk_in);
    #1 check({hsync_out, vsync_out, csync_out, blank_out}, 32'hb);
    check(32'(rgb_out), 32'h0);
  endtask
  task automatic t_flags();
    check(32'(endpoint_irq_status_out), 32'h3);
    wr(8'h04, 32'h0);
    repeat (2) @(posedge clk_in);
    #1 check(32'(endpoint_irq_status_out), 32'h3);
    wr(8'h04, 32'h2);
    repeat (2) @(posedge clk_in);
    #1 check(32'(endpoint_irq_status_out), 32'h2);
    wr(8'h04, 32'h4);
    rd(8'h04, 32'h0);
  endtask
  task automatic t_srst();
    wr(8'h00, 32'h00000002);
    repeat (5) @(posedge clk_in);
    wr(8'h00, 32'h00000001);
    repeat (2) @(posedge clk_in);
    #1 check(32'(controller_running_flag_out), 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h031f027f);
    rd(8'h1c, 32'h01eb01e9);
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rd(8'h14, 32'h020c01df);
    rd(8'h24, 32'h0);
    t_run();
    t_stop();
    t_flags();
    t_srst();
    wrap_up();
  end
endmodule
bind display_raster_timing_ctrl display_raster_timing_ctrl_chk chk (.clk_in, .arst_n_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pix_data_in, .pix_req_out, .rgb_out, .hsync_out,
  .vsync_out, .csync_out, .blank_out, .endpoint_irq_status_out, .controller_running_flag_out);
